/* File: inc/spx_if.sv */
// Purpose: Four-wire link plus attention line between host and device
// Assumes: Slave-out is shared; an undriven line floats high through a pull-up
// Notes: The wire level of slave-out is resolved here from its enable
`timescale 1ns/1ns
`default_nettype none
interface spx_if;
  logic sclk;
  logic ssel_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic attn_n;
  logic miso_line;
  assign miso_line = miso_oe ? miso : 1'b1;
  modport dev (input sclk, input ssel_n, input mosi, output miso, output miso_oe,
               output attn_n);
  modport host (output sclk, output ssel_n, output mosi, input miso_line, input attn_n);
endinterface : spx_if
`default_nettype wire

/* File: inc/spx_pkg.sv */
// Purpose: Shared constants and types for the SPI host port link
// Assumes: 10 MHz system clock on both ends
// Notes: Register offsets belong to the host-side controller only
package spx_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int SPI_MAX_HZ = 3_500_000;
  // Fastest legal half period of the link clock, in system cycles, rounded up
  localparam int SCLK_HALF_MIN = (CLK_HZ + 2 * SPI_MAX_HZ - 1) / (2 * SPI_MAX_HZ);
  // Default half period; larger than the minimum to cover both synchronisers
  localparam int SCLK_HALF_DEF = 8;
  localparam int BYTE_W = 8;
  localparam logic [7:0] API_DELIM = 8'h7E;
  localparam logic [7:0] DUMMY_BYTE = 8'h00;
  localparam int SLEEP_MODE_W = 3;
  localparam logic [2:0] SLEEP_MODE_PIN = 3'h1;
  // Device synchroniser order: {sleep pin, mosi, ssel_n, sclk}
  localparam logic [3:0] DEV_SYNC_RST = 4'h2;
  // Host synchroniser order: {attn_n, miso}
  localparam logic [1:0] HOST_SYNC_RST = 2'h3;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TXDATA = 8'h04;
  localparam logic [7:0] OFS_RXDATA = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam int CTRL_SEL_BIT = 0;
  localparam int CTRL_AUTO_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ATTN_BIT = 1;
  localparam int ST_RXFULL_BIT = 2;
  localparam logic HRESP_OKAY = 1'b0;
  typedef enum logic [2:0] {FR_HUNT, FR_LEN_HI, FR_LEN_LO, FR_BODY, FR_CSUM} spx_frame_t;
  typedef enum logic [1:0] {PS_WAIT, PS_SPI, PS_UART} spx_port_t;
  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH} spx_host_st_t;
endpackage : spx_pkg

/* File: rtl/spx_dev.sv */
// Purpose: Slave end of the host SPI port with attention, port choice and pin sleep
// Assumes: Link pins are asynchronous; the link clock is oversampled by REF_CLK_I
// Notes: Sampling limits the usable link rate well below the legal ceiling
//
// Register access over AHB-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Device is slave only; master clocks.
// - Master keeps link clock at most 3.5 MHz.
// - Bytes travel MSB first both ways.
// - Mode 0: idle low, sample rising.
// - Device uses unescaped API frames only.
// - Attention low once data is queued.
// - Attention stays low until all clocked out.
// - Attention always driven, never floating.
// - Shift out at master clock while selected.
// - Slave-out released whenever select high.
// - Master selects low, then shifts master-out.
// - Master answers attention with select and clock.
// - Master-out, select, clock are device inputs.
// - Bytes outside frames are discarded.
// - Both directions may carry frames concurrently.
// - Input pull-ups on until software disables.
// - Sleep pin as peripheral controls pin sleep.
// - Else select low wakes, high sleeps.
// - Neither peripheral: stay awake in mode 1.
// - Empty buffer repeats last bit sent.
// - Master ignores bytes outside frames.
// - First port with input stays active.
module spx_dev (
  input wire logic REF_CLK_I,
  input wire logic RESETN_I,
  spx_if.dev LINK,
  input wire logic [spx_pkg::BYTE_W-1:0] TX_DATA_I,
  input wire logic TX_VALID_I,
  output logic TX_READY_O,
  output logic [spx_pkg::BYTE_W-1:0] RX_DATA_O,
  output logic RX_VALID_O,
  input wire logic SPI_EN_I,
  input wire logic UART_EN_I,
  input wire logic UART_RX_SEEN_I,
  input wire logic SLEEP_PIN_PERIPH_I,
  input wire logic SSEL_PERIPH_I,
  input wire logic [spx_pkg::SLEEP_MODE_W-1:0] SLEEP_MODE_I,
  input wire logic SLEEP_PIN_I,
  input wire logic PULLUP_DIS_I,
  output logic SPI_ACTIVE_O,
  output logic ASLEEP_O,
  output logic PULLUP_EN_O
);
  import spx_pkg::*;

  logic [3:0] sy1_reg;
  logic [3:0] sy2_reg;
  logic [3:0] sy3_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic sclk_low;
  logic sel;
  logic sel_fall;
  logic mosi_s;
  logic sleep_s;
  spx_port_t port_reg;
  logic spi_active_reg;
  logic link_on;
  logic [2:0] bit_cnt_reg;
  logic [7:0] rx_sh_reg;
  logic byte_done;
  logic [7:0] rx_byte;
  logic keep;
  logic [7:0] tx_sh_reg;
  logic tx_live_reg;
  logic miso_reg;
  logic miso_oe_reg;
  logic attn_n_reg;
  logic pend_valid_reg;
  logic [7:0] pend_data_reg;
  logic tx_ready_reg;
  logic accept;
  logic load;
  logic pend_next;
  logic [7:0] rx_data_reg;
  logic rx_valid_reg;
  logic sleep_req;
  logic asleep_reg;
  logic pullup_en_reg;

  // Link pins are inputs only and pass two flops before use
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      sy1_reg <= DEV_SYNC_RST;
      sy2_reg <= DEV_SYNC_RST;
      sy3_reg <= DEV_SYNC_RST;
    end else begin
      sy1_reg <= {SLEEP_PIN_I, LINK.mosi, LINK.ssel_n, LINK.sclk};
      sy2_reg <= sy1_reg;
      sy3_reg <= sy2_reg;
    end
  end

  // Edges come from the master's clock and, for port choice, from select
  assign sclk_rise = sy2_reg[0] & ~sy3_reg[0];
  assign sclk_fall = ~sy2_reg[0] & sy3_reg[0];
  assign sclk_low = ~sy2_reg[0];
  assign sel = ~sy2_reg[1];
  assign sel_fall = ~sy2_reg[1] & sy3_reg[1];
  assign mosi_s = sy2_reg[2];
  assign sleep_s = sy2_reg[3];

  // Port choice is locked until reset once decided
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      port_reg <= PS_WAIT;
      spi_active_reg <= 1'b0;
    end else begin
      spi_active_reg <= (port_reg == PS_SPI);
      case (port_reg)
        PS_WAIT: begin
          if (!SPI_EN_I) begin
            port_reg <= PS_UART;
          end else if (!UART_EN_I) begin
            port_reg <= PS_SPI;
          end else if (sel_fall) begin
            port_reg <= PS_SPI;
          end else if (UART_RX_SEEN_I) begin
            port_reg <= PS_UART;
          end
        end
        PS_SPI, PS_UART: port_reg <= port_reg;
        default: port_reg <= PS_WAIT;
      endcase
    end
  end

  assign link_on = SPI_EN_I & (port_reg != PS_UART);

  // Capture master-out on rising edges, MSB first
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      bit_cnt_reg <= 3'h0;
      rx_sh_reg <= 8'h00;
    end else if (!sel || !link_on) begin
      bit_cnt_reg <= 3'h0;
    end else if (sclk_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      rx_sh_reg <= {rx_sh_reg[6:0], mosi_s};
    end
  end

  assign byte_done = link_on & sel & sclk_rise & (bit_cnt_reg == 3'h7);
  assign rx_byte = {rx_sh_reg[6:0], mosi_s};

  spx_framer u_rx_framer (
    .clk_i(REF_CLK_I),
    .rst_n_i(RESETN_I),
    .byte_valid_i(byte_done),
    .byte_i(rx_byte),
    .keep_o(keep)
  );

  // Only framed bytes reach the user; receive runs even while sending
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rx_valid_reg <= 1'b0;
      rx_data_reg <= 8'h00;
    end else begin
      rx_valid_reg <= keep;
      if (keep) begin
        rx_data_reg <= rx_byte;
      end
    end
  end

  // Load between bytes while the clock rests low: covers select fall and gaps
  assign load = link_on & sel & sclk_low & ~tx_live_reg & pend_valid_reg &
                (bit_cnt_reg == 3'h0);
  assign accept = TX_VALID_I & tx_ready_reg;
  assign pend_next = accept | (pend_valid_reg & ~load);

  // One-byte holding stage; the user supplies API frames unescaped
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pend_valid_reg <= 1'b0;
      pend_data_reg <= 8'h00;
      tx_ready_reg <= 1'b0;
    end else begin
      pend_valid_reg <= pend_next;
      tx_ready_reg <= ~pend_next;
      if (accept) begin
        pend_data_reg <= TX_DATA_I;
      end
    end
  end

  // Slave-out changes on falling edges, MSB first
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      tx_sh_reg <= 8'h00;
      tx_live_reg <= 1'b0;
      miso_reg <= 1'b0;
    end else if (!sel || !link_on) begin
      // A byte cut short by deselect is lost, not resent
      tx_live_reg <= 1'b0;
    end else if (load) begin
      tx_sh_reg <= pend_data_reg;
      miso_reg <= pend_data_reg[7];
      tx_live_reg <= 1'b1;
    end else if (byte_done) begin
      // Nothing new: miso_reg keeps the last bit for later clocks
      tx_live_reg <= 1'b0;
    end else if (sclk_fall && tx_live_reg) begin
      tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
      miso_reg <= tx_sh_reg[6];
    end
  end

  // Release the shared line whenever select is high
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      miso_oe_reg <= 1'b0;
    end else begin
      miso_oe_reg <= link_on & sel;
    end
  end

  // Low while anything waits or is on its way out
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      attn_n_reg <= 1'b1;
    end else begin
      attn_n_reg <= ~(link_on & (pend_valid_reg | tx_live_reg | accept));
    end
  end

  // Sleep source chosen by which pin is a peripheral
  always_comb begin
    sleep_req = 1'b0;
    if (SLEEP_PIN_PERIPH_I) begin
      sleep_req = sleep_s;
    end else if (SSEL_PERIPH_I) begin
      sleep_req = ~sel;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      asleep_reg <= 1'b0;
    end else begin
      asleep_reg <= (SLEEP_MODE_I == SLEEP_MODE_PIN) & sleep_req;
    end
  end

  // Pull-ups default on so unconnected link pins idle safely
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pullup_en_reg <= 1'b1;
    end else begin
      pullup_en_reg <= ~PULLUP_DIS_I;
    end
  end

  assign LINK.miso = miso_reg;
  assign LINK.miso_oe = miso_oe_reg;
  // Driven at all times, high when idle
  assign LINK.attn_n = attn_n_reg;
  assign TX_READY_O = tx_ready_reg;
  assign RX_DATA_O = rx_data_reg;
  assign RX_VALID_O = rx_valid_reg;
  assign SPI_ACTIVE_O = spi_active_reg;
  assign ASLEEP_O = asleep_reg;
  assign PULLUP_EN_O = pullup_en_reg;
endmodule : spx_dev
`default_nettype wire

/* File: rtl/spx_framer.sv */
// Purpose: Tracks unescaped API frames in a byte stream
// Assumes: One byte per byte_valid_i pulse
// Notes: A delimiter value inside a frame body is plain data
`timescale 1ns/1ns
`default_nettype none
module spx_framer (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  output logic keep_o
);
  import spx_pkg::*;
  spx_frame_t state_reg;
  logic [7:0] len_hi_reg;
  logic [15:0] left_reg;
  logic [15:0] len_full;

  assign len_full = {len_hi_reg, byte_i};
  // Bytes outside a frame are dropped by the caller
  assign keep_o = byte_valid_i & ((state_reg != FR_HUNT) | (byte_i == API_DELIM));

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= FR_HUNT;
      len_hi_reg <= 8'h00;
      left_reg <= 16'h0000;
    end else if (byte_valid_i) begin
      // No escape decoding anywhere in the walk
      case (state_reg)
        FR_HUNT: begin
          if (byte_i == API_DELIM) begin
            state_reg <= FR_LEN_HI;
          end
        end
        FR_LEN_HI: begin
          len_hi_reg <= byte_i;
          state_reg <= FR_LEN_LO;
        end
        FR_LEN_LO: begin
          left_reg <= len_full;
          state_reg <= (len_full == 16'h0000) ? FR_CSUM : FR_BODY;
        end
        FR_BODY: begin
          left_reg <= left_reg - 16'h0001;
          if (left_reg == 16'h0001) begin
            state_reg <= FR_CSUM;
          end
        end
        FR_CSUM: begin
          state_reg <= FR_HUNT;
        end
        default: begin
          state_reg <= FR_HUNT;
        end
      endcase
    end
  end
endmodule : spx_framer
`default_nettype wire

/* File: rtl/spx_host.sv */
// Purpose: SPI master controller reached over AHB-Lite
// Assumes: Single word transfers, zero wait states
// Notes: Link clock is made here by dividing REF_CLK_I
`timescale 1ns/1ns
`default_nettype none
module spx_host #(
  parameter int SCLK_HALF = spx_pkg::SCLK_HALF_DEF
) (
  input wire logic REF_CLK_I,
  input wire logic RESETN_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  output logic [31:0] HRDATA_O,
  spx_if.host LINK
);
  import spx_pkg::*;

  localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF - 1);
  logic [1:0] sy1_reg;
  logic [1:0] sy2_reg;
  logic miso_s;
  logic attn_s;
  logic ap_take;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [1:0] ctrl_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic auto_sel_reg;
  logic ssel_n_reg;
  spx_host_st_t st_reg;
  logic [7:0] div_reg;
  logic [2:0] bits_reg;
  logic [7:0] sh_reg;
  logic [7:0] rx_sh_reg;
  logic sclk_reg;
  logic mosi_reg;
  logic sw_tx;
  logic start;
  logic [7:0] start_data;
  logic xfer_end;
  logic done_reg;
  logic keep;
  logic rx_rd;
  logic rx_full_reg;
  logic [7:0] rx_data_reg;

  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      sy1_reg <= HOST_SYNC_RST;
      sy2_reg <= HOST_SYNC_RST;
    end else begin
      sy1_reg <= {LINK.attn_n, LINK.miso_line};
      sy2_reg <= sy1_reg;
    end
  end

  assign miso_s = sy2_reg[0];
  assign attn_s = ~sy2_reg[1];
  assign ap_take = HSEL_I & HREADY_I & HTRANS_I[1];
  assign rx_rd = ap_take & ~HWRITE_I & (HADDR_I[7:0] == OFS_RXDATA);

  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hreadyout_reg <= 1'b1;
    end else begin
      wr_pend_reg <= ap_take & HWRITE_I;
      wr_addr_reg <= HADDR_I[7:0];
      hreadyout_reg <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_pend_reg && wr_addr_reg == OFS_CTRL) begin
      ctrl_reg <= HWDATA_I[1:0];
    end
  end

  // Unmapped offsets read as zero
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (ap_take && !HWRITE_I) begin
      case (HADDR_I[7:0])
        OFS_CTRL: hrdata_reg <= {30'h0000_0000, ctrl_reg};
        OFS_RXDATA: hrdata_reg <= {24'h00_0000, rx_data_reg};
        OFS_STATUS: hrdata_reg <= {29'h0000_0000, rx_full_reg, attn_s, st_reg != H_IDLE};
        default: hrdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // Software write needs select already low; auto mode serves attention
  assign sw_tx = wr_pend_reg & (wr_addr_reg == OFS_TXDATA);
  assign start = (st_reg == H_IDLE) & ~ssel_n_reg & (sw_tx | (auto_sel_reg & attn_s));
  assign start_data = sw_tx ? HWDATA_I[7:0] : DUMMY_BYTE;

  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      auto_sel_reg <= 1'b0;
      ssel_n_reg <= 1'b1;
    end else begin
      if (st_reg == H_IDLE) begin
        auto_sel_reg <= ctrl_reg[CTRL_AUTO_BIT] & attn_s;
      end
      ssel_n_reg <= ~(ctrl_reg[CTRL_SEL_BIT] | auto_sel_reg);
    end
  end

  assign xfer_end = (st_reg == H_HIGH) & (div_reg == HALF_LAST) & (bits_reg == 3'h7);

  // This end makes the clock; mode 0, MSB first
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      st_reg <= H_IDLE;
      div_reg <= 8'h00;
      bits_reg <= 3'h0;
      sh_reg <= 8'h00;
      rx_sh_reg <= 8'h00;
      sclk_reg <= 1'b0;
      mosi_reg <= 1'b0;
    end else begin
      case (st_reg)
        H_IDLE: begin
          if (start) begin
            sh_reg <= start_data;
            mosi_reg <= start_data[7];
            div_reg <= 8'h00;
            bits_reg <= 3'h0;
            st_reg <= H_LOW;
          end
        end
        H_LOW: begin
          div_reg <= div_reg + 8'h01;
          if (div_reg == HALF_LAST) begin
            div_reg <= 8'h00;
            sclk_reg <= 1'b1;
            rx_sh_reg <= {rx_sh_reg[6:0], miso_s};
            st_reg <= H_HIGH;
          end
        end
        H_HIGH: begin
          div_reg <= div_reg + 8'h01;
          if (div_reg == HALF_LAST) begin
            div_reg <= 8'h00;
            sclk_reg <= 1'b0;
            if (bits_reg == 3'h7) begin
              st_reg <= H_IDLE;
            end else begin
              bits_reg <= bits_reg + 3'h1;
              sh_reg <= {sh_reg[6:0], 1'b0};
              mosi_reg <= sh_reg[6];
              st_reg <= H_LOW;
            end
          end
        end
        default: st_reg <= H_IDLE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= xfer_end;
    end
  end

  spx_framer u_rx_framer (
    .clk_i(REF_CLK_I),
    .rst_n_i(RESETN_I),
    .byte_valid_i(done_reg),
    .byte_i(rx_sh_reg),
    .keep_o(keep)
  );

  // A new framed byte wins over a read clearing the flag
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rx_full_reg <= 1'b0;
      rx_data_reg <= 8'h00;
    end else if (keep) begin
      rx_full_reg <= 1'b1;
      rx_data_reg <= rx_sh_reg;
    end else if (rx_rd) begin
      rx_full_reg <= 1'b0;
    end
  end

  assign HREADYOUT_O = hreadyout_reg;
  assign HRESP_O = HRESP_OKAY;
  assign HRDATA_O = hrdata_reg;
  assign LINK.sclk = sclk_reg;
  assign LINK.ssel_n = ssel_n_reg;
  assign LINK.mosi = mosi_reg;
endmodule : spx_host
`default_nettype wire

/* File: verification/spi_slave_host_port_test.sv */
// Purpose: Host and device ends joined over one link, driven over AHB-Lite and the user side
// Assumes: Both ends on one 10 MHz clock; host half period left at its default
// Notes: Each round carries framed traffic both ways at once, with noise bytes around it
`timescale 1ns/1ns
`default_nettype none
module spi_slave_host_port_test;
  import spx_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hready, hresp, tx_ready, rx_valid, spi_act, asleep, pu_en;
  logic [31:0] hrdata;
  logic [7:0] tx_data = 8'h00;
  logic [7:0] rx_data;
  logic tx_valid = 1'b0;
  logic pin_per = 1'b0;
  logic ssel_per = 1'b0;
  logic [2:0] sl_mode = 3'h0;
  logic sl_pin = 1'b0;
  logic pu_dis = 1'b0;
  logic uart_seen = 1'b0;
  int errors = 0;
  int checked = 0;
  int bc = 0;
  logic [31:0] seed = 32'h8E40;
  logic [7:0] dq[$], wq[$], sq[$], rq[$];
  logic [7:0] mo_sh, mi_sh;
  logic [3:0] sc [5] = '{4'h5, 4'h4, 4'hA, 4'h8, 4'h2};
  spx_if link ();
  spx_dev u_spx_dev (.REF_CLK_I(clk), .RESETN_I(rst_n), .LINK(link), .TX_DATA_I(tx_data),
    .TX_VALID_I(tx_valid), .TX_READY_O(tx_ready), .RX_DATA_O(rx_data), .RX_VALID_O(rx_valid),
    .SPI_EN_I(1'b1), .UART_EN_I(1'b1), .UART_RX_SEEN_I(uart_seen), .SLEEP_PIN_PERIPH_I(pin_per),
    .SSEL_PERIPH_I(ssel_per), .SLEEP_MODE_I(sl_mode), .SLEEP_PIN_I(sl_pin),
    .PULLUP_DIS_I(pu_dis), .SPI_ACTIVE_O(spi_act), .ASLEEP_O(asleep), .PULLUP_EN_O(pu_en));
  spx_host u_spx_host (.REF_CLK_I(clk), .RESETN_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .HRDATA_O(hrdata), .LINK(link));
  spx_asserts u_spx_asserts (.REF_CLK_I(clk), .RESETN_I(rst_n), .sclk(link.sclk),
    .ssel_n(link.ssel_n), .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe),
    .attn_n(link.attn_n));
  initial begin
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [7:0] csum(input logic [7:0] a, input logic [7:0] b);
    return 8'hFF - a - b;
  endfunction : csum
  // Sleep source: sleep pin if peripheral, else select, else never
  function automatic logic sleep_exp(input logic [3:0] c);
    return c[3] ? c[1] : (c[2] ? !c[0] : 1'b0);
  endfunction : sleep_exp
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task finish_test;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task tmo;
    chk(32'h0, 32'h1);
    finish_test;
  endtask : tmo
  task wrdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 100) tmo;
      @(posedge clk);
    end
  endtask : wrdy
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wrdy;
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wrdy;
    r = hrdata;
  endtask : ahb
  // Both lanes sampled on link clock rises, as the far side would
  always @(posedge link.sclk or posedge link.ssel_n) begin
    if (link.ssel_n) begin
      bc = 0;
    end else begin
      mo_sh = {mo_sh[6:0], link.mosi};
      mi_sh = {mi_sh[6:0], link.miso_line};
      bc++;
      if (bc == 8) begin
        wq.push_back(mo_sh);
        sq.push_back(mi_sh);
        bc = 0;
      end
    end
  end
  always @(posedge clk) begin
    if (rx_valid === 1'b1) rq.push_back(rx_data);
    if (tx_valid !== 1'b1 || tx_ready === 1'b1) begin
      if (dq.size() > 0) begin
        tx_data <= dq.pop_front();
        tx_valid <= 1'b1;
      end else begin
        tx_valid <= 1'b0;
      end
    end
  end
  task round;
    logic [31:0] r;
    logic [7:0] hb [7];
    logic [7:0] db [5];
    int n;
    seed = lfsr(seed);
    db = '{API_DELIM, 8'h00, 8'h01, seed[7:0], csum(seed[7:0], 8'h00)};
    hb = '{8'h55, API_DELIM, 8'h00, 8'h02, seed[15:8], seed[23:16], csum(seed[15:8], seed[23:16])};
    foreach (db[i]) dq.push_back(db[i]);
    repeat (10) @(posedge clk);
    chk(32'(link.attn_n), 32'h0);
    ahb(1'b1, OFS_CTRL, 32'h1, r);
    repeat (4) @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      ahb(1'b1, OFS_TXDATA, {24'h0, hb[i]}, r);
      n = 0;
      do begin
        ahb(1'b0, OFS_STATUS, 32'h0, r);
        n++;
        if (n > 300) tmo;
      end while (r[ST_BUSY_BIT] !== 1'b0);
      repeat (6) @(posedge clk);
      ahb(1'b0, OFS_STATUS, 32'h0, r);
      chk(32'(r[ST_RXFULL_BIT]), 32'(i < 5));
      if (i < 5) begin
        ahb(1'b0, OFS_RXDATA, 32'h0, r);
        chk(r, 32'(db[i]));
      end
    end
    chk(32'(link.attn_n), 32'h1);
    ahb(1'b1, OFS_CTRL, 32'h0, r);
    repeat (10) @(posedge clk);
    chk(32'(wq.size()), 32'h7);
    chk(32'(sq.size()), 32'h7);
    foreach (hb[i]) chk(32'(wq.pop_front()), 32'(hb[i]));
    foreach (db[i]) chk(32'(sq.pop_front()), 32'(db[i]));
    repeat (2) chk(32'(sq.pop_front()), 32'({8{db[4][0]}}));
    chk(32'(rq.size()), 32'h6);
    for (int i = 1; i < 7; i++) chk(32'(rq.pop_front()), 32'(hb[i]));
    $display("round done, mismatches so far %0d", errors);
  endtask : round
  initial begin
    repeat (90000) @(posedge clk);
    tmo;
  end
  initial begin
    logic [31:0] r;
    logic [7:0] ab [5];
    int n;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(32'(pu_en), 32'h1);
    chk(32'(link.attn_n), 32'h1);
    repeat (2) round;
    chk(32'(spi_act), 32'h1);
    // Auto mode: the host alone answers attention with dummy bytes
    seed = lfsr(seed);
    ab = '{API_DELIM, 8'h00, 8'h01, seed[31:24], csum(seed[31:24], 8'h00)};
    foreach (ab[i]) dq.push_back(ab[i]);
    ahb(1'b1, OFS_CTRL, 32'h2, r);
    n = 0;
    while (dq.size() > 0 || link.attn_n !== 1'b1 || link.ssel_n !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > 5000) tmo;
    end
    repeat (6) @(posedge clk);
    ahb(1'b0, OFS_RXDATA, 32'h0, r);
    chk(r, 32'(ab[4]));
    ahb(1'b1, OFS_CTRL, 32'h0, r);
    chk(32'(sq.size()), 32'h5);
    foreach (ab[i]) chk(32'(sq.pop_front()), 32'(ab[i]));
    foreach (ab[i]) chk(32'(wq.pop_front()), 32'(DUMMY_BYTE));
    chk(32'(rq.size()), 32'h0);
    $display("auto mode done, mismatches so far %0d", errors);
    pu_dis <= 1'b1;
    repeat (4) @(posedge clk);
    chk(32'(pu_en), 32'h0);
    foreach (sc[i]) begin
      pin_per <= sc[i][3];
      ssel_per <= sc[i][2];
      sl_pin <= sc[i][1];
      sl_mode <= SLEEP_MODE_PIN;
      ahb(1'b1, OFS_CTRL, 32'(sc[i][0]), r);
      repeat (10) @(posedge clk);
      chk(32'(asleep), 32'(sleep_exp(sc[i])));
    end
    pin_per <= 1'b1;
    sl_pin <= 1'b1;
    sl_mode <= 3'h0;
    repeat (10) @(posedge clk);
    chk(32'(asleep), 32'h0);
    $display("sleep cases done, mismatches so far %0d", errors);
    // Second reset: UART input first locks the link out
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    uart_seen <= 1'b1;
    @(posedge clk);
    uart_seen <= 1'b0;
    dq.push_back(API_DELIM);
    repeat (10) @(posedge clk);
    chk(32'(spi_act), 32'h0);
    chk(32'(link.attn_n), 32'h1);
    $display("port lock done, mismatches so far %0d", errors);
    finish_test;
  end
endmodule : spi_slave_host_port_test
`default_nettype wire

/* File: verification/spx_asserts.sv */
// Purpose: Link timing checks between the host and device ends
// Assumes: Host built with the default half period of 8 cycles
// Notes: Sees only link wires; sleep and port choice are judged by the bench
`timescale 1ns/1ns
`default_nettype none
module spx_asserts (
  input wire logic REF_CLK_I,
  input wire logic RESETN_I,
  input wire logic sclk,
  input wire logic ssel_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic attn_n
);
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RESETN_I);
  sclk_high_a: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("link clock high phase is not 8 cycles");
  sclk_low_a: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("link clock low phase too short");
  sel_frame_a: assert property (sclk |-> !ssel_n && $stable(ssel_n))
    else $error("select moved while link clock high");
  mosi_hold_a: assert property (sclk |-> $stable(mosi))
    else $error("host data moved while link clock high");
  miso_hold_a: assert property (sclk && $past(sclk) && !ssel_n && miso_oe |-> $stable(miso))
    else $error("device data moved while link clock high");
  miso_off_a: assert property (ssel_n [*5] |-> !miso_oe)
    else $error("device data still driven while deselected");
  oe_on_a: assert property ($fell(ssel_n) |-> ##[1:6] miso_oe)
    else $error("device data not driven after select");
  attn_rise_a: assert property ($rose(attn_n) |-> !$past(ssel_n, 2) && $past(sclk, 2))
    else $error("attention released outside a clocked byte");
  attn_hold_a: assert property (!attn_n && ssel_n |=> !attn_n)
    else $error("attention released while deselected");
  cover property ($fell(ssel_n));
  cover property ($fell(attn_n));
  cover property ($rose(attn_n));
endmodule : spx_asserts
`default_nettype wire
